//--- core/hss_sequencer.sv
// Hot swap control sequencer: steers gate drive and timing node sources.
// Assumes analog comparators feed the inputs and analog blocks act on the selects.
`timescale 1ns/10ps
`include "hss_defs.svh"
module hss_sequencer
  import hss_pkg::*;
#(
  parameter bit AUTO_RETRY = 1'b0,
  parameter int ON_FILTER_CYC = `HSS_ON_GLITCH_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_lockout_i,
  input wire logic enable_cmp_i,
  input wire logic timer_high_threshold_i,
  input wire logic timer_low_threshold_i,
  input wire logic oc_timing_i,
  input wire logic current_limit_i,
  input wire logic oc_fast_i,
  output logic gate_pullup_o,
  output logic gate_regulate_o,
  output logic gate_pulldown_o,
  output logic gate_strong_pulldown_o,
  output logic [3:0] timing_capacitor_src_o,
  output logic fault_o,
  output hss_state_t state_o
);
  localparam int NSYNC = 7;

  initial begin
    if (ON_FILTER_CYC < 1) begin
      $error("hss_sequencer: ON_FILTER_CYC must be at least 1");
    end
  end

  // Comparator inputs are analog and asynchronous to clk_i
  // two-flop synchronisers
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {supply_lockout_i, enable_cmp_i, timer_high_threshold_i,
                    timer_low_threshold_i, oc_timing_i, current_limit_i, oc_fast_i};
      sync2_reg <= sync1_reg;
    end
  end

  logic lockout_s;
  logic en_s;
  logic thi_s;
  logic tlo_s;
  logic oct_s;
  logic lim_s;
  logic ocf_s;
  assign {lockout_s, en_s, thi_s, tlo_s, oct_s, lim_s, ocf_s} = sync2_reg;

  logic en_q;
  hss_glitch_filter #(
    .CYCLES(ON_FILTER_CYC)
  ) u_on_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .din_i(en_s),
    .dout_o(en_q)
  );

  logic en_q_d_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q_d_reg <= 1'b0;
    end else begin
      en_q_d_reg <= en_q;
    end
  end
  logic en_rise;
  assign en_rise = en_q && !en_q_d_reg;

  hss_state_t state_reg;
  hss_state_t state_next;

  // Sequencer transitions
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HSS_ST_RESET: begin
        if (!lockout_s) begin
          state_next = HSS_ST_INIT_UP;
        end
      end
      HSS_ST_INIT_UP: begin
        if (thi_s) begin
          state_next = HSS_ST_INIT_DN;
        end
      end
      HSS_ST_INIT_DN: begin
        if (tlo_s) begin
          state_next = HSS_ST_WAIT_EN;
        end
      end
      HSS_ST_WAIT_EN: begin
        if (en_q) begin
          state_next = HSS_ST_RAMP;
        end
      end
      HSS_ST_RAMP: begin
        if (thi_s && oct_s) begin
          state_next = AUTO_RETRY ? HSS_ST_COOL : HSS_ST_FAULT;
        end else if (!oct_s && !lim_s && gate_pullup_o) begin
          state_next = HSS_ST_ON;
        end
      end
      HSS_ST_ON: begin
        if (oct_s) begin
          state_next = HSS_ST_RAMP;
        end
      end
      HSS_ST_FAULT: begin
        if (en_rise) begin
          state_next = HSS_ST_RAMP;
        end
      end
      HSS_ST_COOL: begin
        if (tlo_s) begin
          state_next = HSS_ST_RAMP;
        end
      end
    endcase
    if (!en_q && (state_reg == HSS_ST_RAMP || state_reg == HSS_ST_ON ||
                  state_reg == HSS_ST_FAULT || state_reg == HSS_ST_COOL)) begin
      state_next = HSS_ST_WAIT_EN;
    end
    if (en_rise && (state_reg == HSS_ST_WAIT_EN || state_reg == HSS_ST_FAULT)) begin
      state_next = HSS_ST_RAMP;
    end
    if (lockout_s) begin
      state_next = HSS_ST_RESET;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= HSS_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Gate drive mode for the next state
  logic [1:0] gate_next;
  always_comb begin
    gate_next = `HSS_GATE_PULLDN;
    unique case (state_next)
      HSS_ST_RAMP: begin
        gate_next = lim_s ? `HSS_GATE_REGULATE : `HSS_GATE_CHARGE;
      end
      HSS_ST_ON: begin
        gate_next = `HSS_GATE_FULL;
      end
      default: begin
        gate_next = `HSS_GATE_PULLDN;
      end
    endcase
    if (ocf_s) begin
      gate_next = `HSS_GATE_PULLDN;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_pullup_o <= 1'b0;
      gate_regulate_o <= 1'b0;
      gate_pulldown_o <= 1'b1;
    end else begin
      gate_pullup_o <= (gate_next == `HSS_GATE_CHARGE) || (gate_next == `HSS_GATE_FULL);
      gate_regulate_o <= (gate_next == `HSS_GATE_REGULATE);
      gate_pulldown_o <= (gate_next == `HSS_GATE_PULLDN);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_strong_pulldown_o <= 1'b1;
    end else begin
      gate_strong_pulldown_o <= (state_next == HSS_ST_RESET);
    end
  end

  // Timing node source select
  // four node sources
  logic [3:0] tmr_next;
  always_comb begin
    tmr_next = `HSS_TMR_RESET_DN;
    unique case (state_next)
      HSS_ST_RESET: tmr_next = `HSS_TMR_RESET_DN;
      HSS_ST_INIT_UP: tmr_next = `HSS_TMR_INIT_UP;
      HSS_ST_INIT_DN: tmr_next = `HSS_TMR_RESET_DN;
      HSS_ST_WAIT_EN: tmr_next = `HSS_TMR_RESET_DN;
      HSS_ST_RAMP: tmr_next = oct_s ? `HSS_TMR_FAULT_UP : `HSS_TMR_RESET_DN;
      HSS_ST_ON: tmr_next = `HSS_TMR_RESET_DN;
      // Latched fault keeps node parked low until enable cycles
      HSS_ST_FAULT: tmr_next = `HSS_TMR_RESET_DN;
      HSS_ST_COOL: tmr_next = `HSS_TMR_COOL_DN;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timing_capacitor_src_o <= `HSS_TMR_RESET_DN;
    end else begin
      timing_capacitor_src_o <= tmr_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else if (state_reg == HSS_ST_RAMP &&
                 (state_next == HSS_ST_FAULT || state_next == HSS_ST_COOL)) begin
      fault_o <= 1'b1;
    end else if (state_next == HSS_ST_RAMP || state_next == HSS_ST_RESET ||
                 state_next == HSS_ST_WAIT_EN) begin
      fault_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_o <= HSS_ST_RESET;
    end else begin
      state_o <= state_next;
    end
  end
endmodule

//--- include/hss_defs.svh
// Constants for the hot swap sequencer: filter timing and output encodings.
// Assumes a single 250 MHz clock; included by bare name.
`ifndef HSS_DEFS_SVH
`define HSS_DEFS_SVH

`define HSS_CLK_PERIOD_NS 4
`define HSS_ON_GLITCH_NS 3000
`define HSS_ON_GLITCH_CYC ((`HSS_ON_GLITCH_NS + `HSS_CLK_PERIOD_NS - 1) / `HSS_CLK_PERIOD_NS)

// Timing node source select, one-hot
`define HSS_TMR_NONE 4'h0
`define HSS_TMR_INIT_UP 4'h1
`define HSS_TMR_FAULT_UP 4'h2
`define HSS_TMR_COOL_DN 4'h4
`define HSS_TMR_RESET_DN 4'h8

// Gate drive mode
`define HSS_GATE_PULLDN 2'h0
`define HSS_GATE_CHARGE 2'h1
`define HSS_GATE_REGULATE 2'h2
`define HSS_GATE_FULL 2'h3

`endif

//--- include/hss_pkg.sv
// Types shared by the hot swap sequencer files.
// Assumes hss_defs.svh is on the include path.
package hss_pkg;
  typedef enum logic [2:0] {
    HSS_ST_RESET,
    HSS_ST_INIT_UP,
    HSS_ST_INIT_DN,
    HSS_ST_WAIT_EN,
    HSS_ST_RAMP,
    HSS_ST_ON,
    HSS_ST_FAULT,
    HSS_ST_COOL
  } hss_state_t;
endpackage

//--- core/hss_glitch_filter.sv
// Digital glitch filter: output follows input only after it stays stable.
// Assumes the input is already synchronised to clk_i.
`timescale 1ns/10ps
module hss_glitch_filter #(
  parameter int CYCLES = 750
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic din_i,
  output logic dout_o
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;
  logic dout_reg;

  initial begin
    if (CYCLES < 1) begin
      $error("hss_glitch_filter: CYCLES must be at least 1");
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (din_i == dout_reg) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // Change taken only after a full stable interval
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dout_reg <= 1'b0;
    end else if (din_i != dout_reg && cnt_reg == CW'(CYCLES - 1)) begin
      dout_reg <= din_i;
    end
  end

  assign dout_o = dout_reg;
endmodule

//--- dv/hss_seq_sva.sv
// Port-level checker for the hot swap sequencer.
// Bound to every sequencer instance; hss_pkg is compiled first.
`timescale 1ns/10ps
module hss_seq_sva
  import hss_pkg::*;
#(
  parameter int ON_FILTER_CYC = 750
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_lockout_i,
  input wire logic enable_cmp_i,
  input wire logic oc_fast_i,
  input wire logic gate_pullup_o,
  input wire logic gate_pulldown_o,
  input wire logic gate_strong_pulldown_o,
  input wire logic [3:0] timing_capacitor_src_o,
  input wire logic fault_o,
  input wire hss_state_t state_o
);
  // Saturates so a long off period never wraps under the limit
  logic [7:0] low_cnt_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_reg <= 8'h00;
    end else if (enable_cmp_i) begin
      low_cnt_reg <= 8'h00;
    end else if (low_cnt_reg != 8'hFF) begin
      low_cnt_reg <= low_cnt_reg + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_lockout_reset: assert property (
    supply_lockout_i [*4] |=> state_o == HSS_ST_RESET && gate_strong_pulldown_o
    && timing_capacitor_src_o == 4'h8) else $error("lockout not held");
  a_gate_held: assert property (
    state_o inside {HSS_ST_RESET, HSS_ST_INIT_UP, HSS_ST_INIT_DN, HSS_ST_WAIT_EN,
    HSS_ST_FAULT} |-> gate_pulldown_o && !gate_pullup_o) else $error("gate not off");
  a_init_charge: assert property (
    state_o == HSS_ST_INIT_UP |-> timing_capacitor_src_o == 4'h1)
    else $error("init source wrong");
  a_init_order: assert property (
    state_o == HSS_ST_WAIT_EN && $past(state_o) != HSS_ST_WAIT_EN
    |-> !($past(state_o) inside {HSS_ST_RESET, HSS_ST_INIT_UP}))
    else $error("init cycle skipped");
  a_ramp_entry: assert property (
    $changed(state_o) && state_o == HSS_ST_RAMP |-> $past(state_o) inside
    {HSS_ST_WAIT_EN, HSS_ST_ON, HSS_ST_FAULT, HSS_ST_COOL}) else $error("bad ramp entry");
  a_full_on: assert property (
    state_o == HSS_ST_ON |-> timing_capacitor_src_o == 4'h8) else $error("on source");
  a_fault_flag: assert property (
    $rose(fault_o) |-> state_o inside {HSS_ST_FAULT, HSS_ST_COOL} && gate_pulldown_o)
    else $error("fault without gate off");
  a_fast_trip: assert property (
    oc_fast_i [*4] |=> gate_pulldown_o) else $error("fast trip ignored");
  a_cool_drain: assert property (
    state_o == HSS_ST_COOL |-> timing_capacitor_src_o == 4'h4) else $error("cool source");
  a_enable_low: assert property (
    low_cnt_reg > ON_FILTER_CYC + 8 |-> gate_pulldown_o
    && !(state_o inside {HSS_ST_RAMP, HSS_ST_ON})) else $error("enable low ignored");
endmodule

bind hss_sequencer hss_seq_sva #(.ON_FILTER_CYC(ON_FILTER_CYC)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .supply_lockout_i(supply_lockout_i),
  .enable_cmp_i(enable_cmp_i), .oc_fast_i(oc_fast_i), .gate_pullup_o(gate_pullup_o),
  .gate_pulldown_o(gate_pulldown_o), .gate_strong_pulldown_o(gate_strong_pulldown_o),
  .timing_capacitor_src_o(timing_capacitor_src_o), .fault_o(fault_o), .state_o(state_o)
);

//--- dv/hss_tcap_model.sv
// Timing capacitor node model with its two threshold comparators.
// Assumes the one-hot source select; node counts in mV per step.
`timescale 1ns/10ps
module hss_tcap_model #(
  parameter int SLOW = 1
) (
  input wire logic clk_i,
  input wire logic [3:0] src_i,
  output logic high_o,
  output logic low_o
);
  int mv = 0;
  int dv;
  int div = 0;
  // four sources; 60 up, 2 down give the retry duty
  always @(posedge clk_i) begin
    case (src_i)
      4'h1: dv = 5;
      4'h2: dv = 60;
      4'h4: dv = -2;
      4'h8: dv = -100;
      default: dv = 0;
    endcase
    div <= (div + 1) % SLOW;
    if (div == 0) begin
      mv <= (mv + dv < 0) ? 0 : mv + dv;
    end
  end
  assign high_o = mv >= 1300;
  assign low_o = mv <= 200;
endmodule

//--- dv/hss_sequencer_tb_top.sv
// Bench for the hot swap sequencer, latch-off and auto-retry side by side.
// Assumes hss_pkg and the sequencer are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module hss_sequencer_tb_top
  import hss_pkg::*;
();
  typedef struct packed {
    logic en; logic oc; hss_state_t st; logic up; logic dn; logic flt; logic [3:0] src;
  } hss_row_t;
  logic clk, rst, lock, en, oc, lim, fast, th1, tl1, th2, tl2;
  logic up1, dn1, sdn1, flt1, flt2;
  logic [3:0] src1, src2;
  hss_state_t st1, st2;
  int errors = 0;
  int n_checks = 0;
  hss_row_t rows [8] = '{
    '{1'h0, 1'h0, HSS_ST_INIT_UP, 1'h0, 1'h1, 1'h0, 4'h1},
    '{1'h0, 1'h0, HSS_ST_INIT_DN, 1'h0, 1'h1, 1'h0, 4'h8},
    '{1'h0, 1'h0, HSS_ST_WAIT_EN, 1'h0, 1'h1, 1'h0, 4'h8},
    '{1'h1, 1'h0, HSS_ST_ON, 1'h1, 1'h0, 1'h0, 4'h8},
    '{1'h1, 1'h1, HSS_ST_RAMP, 1'h0, 1'h0, 1'h0, 4'h2},
    '{1'h1, 1'h1, HSS_ST_FAULT, 1'h0, 1'h1, 1'h1, 4'h8},
    '{1'h0, 1'h0, HSS_ST_WAIT_EN, 1'h0, 1'h1, 1'h0, 4'h8},
    '{1'h1, 1'h0, HSS_ST_ON, 1'h1, 1'h0, 1'h0, 4'h8}};
  hss_sequencer #(.AUTO_RETRY(1'b0), .ON_FILTER_CYC(4)) dut (.clk_i(clk), .rst_i(rst),
    .supply_lockout_i(lock), .enable_cmp_i(en), .timer_high_threshold_i(th1),
    .timer_low_threshold_i(tl1), .oc_timing_i(oc), .current_limit_i(lim),
    .oc_fast_i(fast), .gate_pullup_o(up1), .gate_regulate_o(), .gate_pulldown_o(dn1),
    .gate_strong_pulldown_o(sdn1), .timing_capacitor_src_o(src1), .fault_o(flt1),
    .state_o(st1));
  hss_sequencer #(.AUTO_RETRY(1'b1), .ON_FILTER_CYC(4)) dut_ar (.clk_i(clk), .rst_i(rst),
    .supply_lockout_i(lock), .enable_cmp_i(en), .timer_high_threshold_i(th2),
    .timer_low_threshold_i(tl2), .oc_timing_i(oc), .current_limit_i(lim),
    .oc_fast_i(fast), .gate_pullup_o(), .gate_regulate_o(), .gate_pulldown_o(),
    .gate_strong_pulldown_o(), .timing_capacitor_src_o(src2), .fault_o(flt2), .state_o(st2));
  hss_tcap_model #(.SLOW(1)) m1 (.clk_i(clk), .src_i(src1), .high_o(th1), .low_o(tl1));
  // Slow node on the retry unit stretches every timer wait
  hss_tcap_model #(.SLOW(2)) m2 (.clk_i(clk), .src_i(src2), .high_o(th2), .low_o(tl2));
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_st(input logic ar, input hss_state_t s);
    int k;
    k = 0;
    while ((ar ? st2 : st1) !== s && k < 4000) begin
      @(negedge clk);
      k++;
    end
    repeat (2) @(negedge clk);
    `CHK("state", s, ar ? st2 : st1)
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    rst = 1'b1; lock = 1'b1; en = 1'b0; oc = 1'b0; lim = 1'b0; fast = 1'b0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("lockout state", HSS_ST_RESET, st1)
    `CHK("strong pulldown", 1'h1, sdn1)
    lock = 1'b0;
    foreach (rows[i]) begin
      en = rows[i].en; oc = rows[i].oc; lim = rows[i].oc;
      wait_st(1'b0, rows[i].st);
      `CHK("pullup", rows[i].up, up1)
      `CHK("pulldown", rows[i].dn, dn1)
      `CHK("fault", rows[i].flt, flt1)
      `CHK("node source", rows[i].src, src1)
    end
    en = 1'b0;
    repeat (2) @(negedge clk);
    en = 1'b1;
    repeat (16) @(negedge clk);
    `CHK("glitch", HSS_ST_ON, st1)
    fast = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("fast trip", 1'h1, dn1)
    fast = 1'b0; oc = 1'b1; lim = 1'b1;
    wait_st(1'b1, HSS_ST_COOL);
    `CHK("cool source", 4'h4, src2)
    `CHK("retry fault flag", 1'h1, flt2)
    wait_st(1'b1, HSS_ST_RAMP);
    `CHK("retry source", 4'h2, src2)
    `CHK("retry flag clear", 1'h0, flt2)
    oc = 1'b0; lim = 1'b0; lock = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("relock", HSS_ST_RESET, st2)
    summarize();
  end
endmodule
